// ===== core/asr_host.sv
// Readout host: sends a configuration byte, runs three byte transfers, assembles the result.
// Assumes a 250 MHz clock and a converter on the far side of asr_link_if.
//
// Behaviour
// - Converter hooks to plain serial host directly
// - Host may bit-bang three port lines instead
// - Bytes move MSB first, eight bits each
// - Configuration byte write starts the exchange
// - Three byte transfers fetch one result
// - Byte two carries B11..B7 at bottom
// - Byte three carries B6..B0 plus spare
// - Mask byte two with 1F
// - Mask byte three with FE
// - Concatenate, shift right one, twelve-bit result
// - Serial clock at most 320 kHz
// - Four-wire link carries configuration and readout
// - Poll completion flag before next byte
`default_nettype none
`include "asr_params.svh"

module asr_host (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic          start,
  input  wire asr_pkg::asr_byte_t config_word,
  output logic               ready,
  output logic               result_valid,
  output asr_pkg::asr_result_t result,
  asr_link_if.host           link
);
  import asr_pkg::*;

  // ============================================================
  // Returning data pin synchroniser
  // ============================================================
  logic miso_s1_r;
  logic miso_s2_r;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      miso_s1_r <= 1'b1;
      miso_s2_r <= 1'b1;
    end
    else
    begin
      miso_s1_r <= link.miso_wire;
      miso_s2_r <= miso_s1_r;
    end
  end

  // ============================================================
  // Serial clock divider
  // ============================================================
  localparam logic [`ASR_DIV_W-1:0] HALF_LAST = `ASR_DIV_W'(`ASR_HALF_TICKS - 1);

  asr_hstate_t          state_r;
  logic [`ASR_DIV_W-1:0] div_r;

  // One tick per half serial period keeps the link at or below its limit
  wire tick = (div_r == HALF_LAST);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      div_r <= '0;
    else if (state_r == ASR_ST_IDLE || tick)
      div_r <= '0;
    else
      div_r <= div_r + `ASR_DIV_W'(1);
  end

  // ============================================================
  // Transfer sequencer
  // ============================================================
  logic       sclk_r;
  logic       cs_n_r;
  asr_byte_t  tx_r;
  asr_byte_t  rx_r;
  asr_byte_t  mid_r;
  logic [3:0] bit_r;
  logic [1:0] byte_r;
  logic       transfer_complete_flag;
  asr_result_t result_r;
  logic       valid_r;

  // Result assembly from the two data-bearing bytes
  wire asr_byte_t mid_masked = mid_r & `ASR_MID_MASK;
  wire asr_byte_t low_masked = rx_r & `ASR_LOW_MASK;
  wire [2*`ASR_BYTE_W-1:0] joined  = {mid_masked, low_masked};
  wire [2*`ASR_BYTE_W-1:0] shifted = joined >> 1;

  wire sclk_rising  = tick && !sclk_r;
  wire sclk_falling = tick && sclk_r;
  wire byte_end     = sclk_falling && (bit_r == `ASR_LAST_BIT);
  wire last_byte    = (byte_r == `ASR_LAST_BYTE);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r                <= ASR_ST_IDLE;
      sclk_r                 <= 1'b0;
      cs_n_r                 <= 1'b1;
      tx_r                   <= `ASR_FILL_BYTE;
      rx_r                   <= `ASR_FILL_BYTE;
      mid_r                  <= `ASR_FILL_BYTE;
      bit_r                  <= 4'h0;
      byte_r                 <= 2'h0;
      transfer_complete_flag <= 1'b0;
      result_r               <= '0;
      valid_r                <= 1'b0;
    end
    else
    begin
      valid_r <= 1'b0;
      case (state_r)
        ASR_ST_IDLE:
        begin
          if (start)
          begin
            // Loading the configuration byte is what opens the exchange
            tx_r    <= config_word;
            cs_n_r  <= 1'b0;
            bit_r   <= 4'h0;
            byte_r  <= 2'h0;
            state_r <= ASR_ST_SETUP;
          end
        end
        ASR_ST_SETUP:
        begin
          // A full serial period of select setup before the first edge: half here, half more in shift
          if (tick)
            state_r <= ASR_ST_SHIFT;
        end
        ASR_ST_SHIFT:
        begin
          if (tick)
            sclk_r <= ~sclk_r;
          if (sclk_rising)
            rx_r <= {rx_r[`ASR_BYTE_W-2:0], miso_s2_r};
          if (sclk_falling)
          begin
            tx_r  <= {tx_r[`ASR_BYTE_W-2:0], 1'b0};
            bit_r <= bit_r + 4'h1;
          end
          if (byte_end)
          begin
            transfer_complete_flag <= 1'b1;
            state_r                <= ASR_ST_GAP;
          end
        end
        ASR_ST_GAP:
        begin
          // Next byte only after the completion flag has been seen
          if (tick && transfer_complete_flag)
          begin
            transfer_complete_flag <= 1'b0;
            byte_r                 <= byte_r + 2'h1;
            if (byte_r == `ASR_MID_BYTE)
              mid_r <= rx_r;
            if (last_byte)
            begin
              result_r <= shifted[`ASR_RES_W-1:0];
              state_r  <= ASR_ST_DONE;
            end
            else
            begin
              tx_r    <= `ASR_FILL_BYTE;
              bit_r   <= 4'h0;
              state_r <= ASR_ST_SHIFT;
            end
          end
        end
        ASR_ST_DONE:
        begin
          if (tick)
          begin
            cs_n_r  <= 1'b1;
            valid_r <= 1'b1;
            state_r <= ASR_ST_IDLE;
          end
        end
        default:
        begin
          cs_n_r  <= 1'b1;
          sclk_r  <= 1'b0;
          state_r <= ASR_ST_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // Pins and user side
  // ============================================================
  // Dedicated-port style drive; the same three lines could be bit-banged by software
  assign link.cs_n    = cs_n_r;
  assign link.sclk    = sclk_r;
  assign link.mosi    = tx_r[`ASR_BYTE_W-1];
  assign ready        = (state_r == ASR_ST_IDLE);
  assign result_valid = valid_r;
  assign result       = result_r;

endmodule // asr_host

`default_nettype wire

// ===== core/asr_params.svh
// Named numbers for the serial readout link: timing, framing, result masks.
// Assumes a 250 MHz core clock; included by both link ends.
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

// ============================================================
// Timing
// ============================================================
`define ASR_CLK_KHZ       250000
`define ASR_SCLK_MAX_KHZ  320
`define ASR_SAMPLE_MAX_HZ 16800
// Half serial period, rounded up so the link never runs above its limit
`define ASR_HALF_TICKS    ((`ASR_CLK_KHZ + 2 * `ASR_SCLK_MAX_KHZ - 1) / (2 * `ASR_SCLK_MAX_KHZ))
`define ASR_DIV_W         9

// ============================================================
// Framing
// ============================================================
`define ASR_BYTE_W        8
`define ASR_LAST_BIT      4'h7
`define ASR_LAST_BYTE     2'h2
`define ASR_MID_BYTE      2'h1
`define ASR_FILL_BYTE     8'h00
`define ASR_CFG_LAST_CNT  5'h07
`define ASR_RES_FIRST_CNT 5'h0B
`define ASR_RES_LAST_CNT  5'h16
`define ASR_CNT_MAX       5'h1F

// ============================================================
// Result assembly
// ============================================================
`define ASR_MID_MASK      8'h1F
`define ASR_LOW_MASK      8'hFE
`define ASR_RES_W         12

`endif

// ===== core/asr_pkg.sv
// Types shared by both ends of the serial readout link.
// Assumes asr_params.svh is on the include path.
`default_nettype none
`include "asr_params.svh"

package asr_pkg;
  typedef logic [`ASR_BYTE_W-1:0] asr_byte_t;
  typedef logic [`ASR_RES_W-1:0]  asr_result_t;

  typedef enum logic [4:0] {
    ASR_ST_IDLE  = 5'b0_0001,
    ASR_ST_SETUP = 5'b0_0010,
    ASR_ST_SHIFT = 5'b0_0100,
    ASR_ST_GAP   = 5'b0_1000,
    ASR_ST_DONE  = 5'b1_0000
  } asr_hstate_t;
endpackage

`default_nettype wire

// ===== core/asr_link_if.sv
// Four-wire link between readout host and converter.
// Assumes the converter releases its data pin while deselected; a pull-up holds it high then.
`default_nettype none

interface asr_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  logic miso_wire;

  // Released pin reads high through the pull-up
  assign miso_wire = miso_oe_n ? 1'b1 : miso;

  modport host (output cs_n, output sclk, output mosi, input miso_wire);
  modport conv (input cs_n, input sclk, input mosi, output miso, output miso_oe_n);
endinterface

`default_nettype wire

// ===== core/asr_conv.sv
// Converter end of the readout link: takes the configuration byte, returns a 12-bit sample.
// Assumes the link pins arrive asynchronously and the host keeps the framing.
`default_nettype none
`include "asr_params.svh"

module asr_conv (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire asr_pkg::asr_result_t sample_data,
  output logic               cfg_valid,
  output asr_pkg::asr_byte_t cfg_word,
  asr_link_if.conv           link
);
  import asr_pkg::*;

  // ============================================================
  // Pin synchronisers: bit 2 select, bit 1 clock, bit 0 data in
  // ============================================================
  logic [2:0] pin_raw;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic       sclk_d_r;

  assign pin_raw = {link.cs_n, link.sclk, link.mosi};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_sync
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          sync1_r[g] <= 1'b1;
          sync2_r[g] <= 1'b1;
        end
        else
        begin
          sync1_r[g] <= pin_raw[g];
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  wire sel       = ~sync2_r[2];
  wire sclk_rise = sync2_r[1] & ~sclk_d_r;
  wire sclk_fall = ~sync2_r[1] & sclk_d_r;

  // ============================================================
  // Bit counter, configuration capture, result shifting
  // ============================================================
  logic [4:0]  cnt_r;
  asr_byte_t   cfg_r;
  asr_result_t smp_r;
  logic        dout_r;
  logic        cfg_valid_r;

  // Result bits sit at link bits 11..22: top five at the foot of byte two, rest head byte three
  wire       in_res  = (cnt_r >= `ASR_RES_FIRST_CNT) && (cnt_r <= `ASR_RES_LAST_CNT);
  wire [4:0] res_idx = `ASR_RES_LAST_CNT - cnt_r;
  wire       nxt_bit = in_res ? smp_r[res_idx[3:0]] : 1'b0;
  wire       in_cfg  = cnt_r <= `ASR_CFG_LAST_CNT;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_d_r    <= 1'b1;
      cnt_r       <= 5'h00;
      cfg_r       <= `ASR_FILL_BYTE;
      smp_r       <= '0;
      dout_r      <= 1'b0;
      cfg_valid_r <= 1'b0;
    end
    else
    begin
      sclk_d_r    <= sync2_r[1];
      cfg_valid_r <= 1'b0;
      if (!sel)
      begin
        cnt_r  <= 5'h00;
        dout_r <= 1'b0;
      end
      else if (sclk_rise)
      begin
        if (in_cfg)
          cfg_r <= {cfg_r[`ASR_BYTE_W-2:0], sync2_r[0]};
        // Sample taken once the configuration byte is complete
        if (cnt_r == `ASR_CFG_LAST_CNT)
        begin
          smp_r       <= sample_data;
          cfg_valid_r <= 1'b1;
        end
        if (cnt_r != `ASR_CNT_MAX)
          cnt_r <= cnt_r + 5'h01;
      end
      else if (sclk_fall)
        dout_r <= nxt_bit;
    end
  end

  // Plain mode-0 slave on the four pins, no glue needed at the host
  assign link.miso      = dout_r;
  assign link.miso_oe_n = sync2_r[2];
  assign cfg_word       = cfg_r;
  assign cfg_valid      = cfg_valid_r;

endmodule // asr_conv

`default_nettype wire

// ===== verif/asr_link_asserts.sv
// Checker for the four-wire readout link, fed with the interface signals.
// Assumes one clock domain and mode 0 framing driven by the host end.
`default_nettype none
`include "asr_params.svh"

module asr_link_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire logic miso_wire
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = `ASR_HALF_TICKS;
  logic       sclk_r;
  logic [9:0] run_r;
  logic [4:0] rise_r;
  wire        chg  = sclk != sclk_r;
  wire        rise = sclk && !sclk_r;

  // ==========
  // Phase length and bit index
  // ==========
  // Run length saturates so long idle spells never wrap
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_r <= 1'b0;
      run_r  <= '0;
      rise_r <= '0;
    end
    else
    begin
      sclk_r <= sclk;
      run_r  <= chg ? '0 : run_r + {9'h000, run_r != 10'h3FF};
      rise_r <= cs_n ? '0 : rise_r + {4'h0, rise};
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // ==========
  // Link rules
  // ==========
  a_sclk_half: assert property (chg |-> run_r >= HALF - 1)
    else $error("sclk phase too short");
  a_idle_low: assert property (cs_n |-> !sclk)
    else $error("sclk high while deselected");
  a_cs_setup: assert property ($fell(cs_n) |-> !sclk [*8])
    else $error("sclk rose too soon after select");
  a_frame_len: assert property ($rose(cs_n) |-> rise_r == 5'h18)
    else $error("frame not 24 clocks");
  a_oe_release: assert property ($rose(cs_n) |-> ##[1:6] miso_oe_n)
    else $error("data pin not released");
  a_dead_bits: assert property (rise && !cs_n && rise_r inside {5'h08, 5'h09, 5'h0A, 5'h17} |-> !miso_wire)
    else $error("non-result bit not zero");
  a_mosi_quiet: assert property ($changed(mosi) |-> !sclk)
    else $error("mosi moved with sclk high");
  a_miso_hold: assert property (sclk && $past(sclk) && !cs_n |-> $stable(miso_wire))
    else $error("miso moved with sclk high");

  c_frame: cover property ($rose(cs_n) && rise_r == 5'h18);
  c_one: cover property (rise && !miso_oe_n && miso);
  c_last: cover property (rise && rise_r == 5'h17);
endmodule // asr_link_asserts

`default_nettype wire

// ===== verif/testbench.sv
// Bench: host and converter joined by the link interface; three reads.
// Assumes the core files are compiled first.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import asr_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        start = 1'b0;
  asr_byte_t   cfg_in = '0;
  asr_result_t smp = '0;
  logic        ready, result_valid, cfg_valid;
  asr_result_t result;
  asr_byte_t   cfg_word;
  int          errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  asr_result_t exp_q[$];
  asr_byte_t   cfg_q[$];
  // Expected frame per read: config byte then zero fill, returned bits; the next read queues
  // its frame before the closing select edge of this one is seen, so a single holder would race
  logic [47:0] frm_q[$];
  logic [47:0] frm;
  logic [23:0] mo_sr, mi_sr;
  logic        sclk_d = 1'b0;
  logic        cs_d = 1'b1;

  asr_link_if link ();
  asr_host asr_host_i (.clk(clk), .nrst(nrst), .start(start), .config_word(cfg_in), .ready(ready),
    .result_valid(result_valid), .result(result), .link(link.host));
  asr_conv asr_conv_i (.clk(clk), .nrst(nrst), .sample_data(smp), .cfg_valid(cfg_valid),
    .cfg_word(cfg_word), .link(link.conv));
  asr_link_asserts asr_link_asserts_i (.clk(clk), .nrst(nrst), .cs_n(link.cs_n), .sclk(link.sclk),
    .mosi(link.mosi), .miso(link.miso), .miso_oe_n(link.miso_oe_n), .miso_wire(link.miso_wire));

  always #2 clk = ~clk;

  // ==========
  // Checking and verdict
  // ==========
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Whole-frame capture straight off the wire, MSB first
  always @(posedge clk)
  begin
    sclk_d <= link.sclk;
    cs_d <= link.cs_n;
    if (link.sclk && !sclk_d && !link.cs_n)
    begin
      mo_sr <= {mo_sr[22:0], link.mosi};
      mi_sr <= {mi_sr[22:0], link.miso_wire};
    end
    if (link.cs_n && !cs_d)
    begin
      frm = frm_q.size() > 0 ? frm_q.pop_front() : 'x;
      check("mosi", mo_sr, frm[47:24]);
      check("miso", mi_sr, frm[23:0]);
    end
    if (cfg_valid === 1'b1)
      check("cfg", cfg_word, cfg_q.size() > 0 ? cfg_q.pop_front() : 'x);
    if (result_valid === 1'b1)
      check("result", result, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    cycles++;
    if (cycles == 70000)
    begin
      errors++;
      give_verdict();
    end
  end

  // ==========
  // Stimulus
  // ==========
  task automatic wait_hi(ref logic sig);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < 30000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    // A wait that never ends is a failure, not a skip
    if (n >= 30000)
      errors++;
  endtask

  task automatic pulse();
    start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
  endtask

  // A second start mid-read must be ignored; the sample moves once captured
  task automatic do_read(input asr_result_t s);
    wait_hi(ready);
    smp = s;
    cfg_in = 8'($urandom);
    frm_q.push_back({cfg_in, 16'h0000, 11'h000, s, 1'b0});
    exp_q.push_back(s);
    cfg_q.push_back(cfg_in);
    pulse();
    check("ready", ready, 24'h00_0000);
    repeat (20) @(posedge clk);
    #1;
    cfg_in = ~cfg_in;
    pulse();
    wait_hi(cfg_valid);
    smp = ~s;
  endtask

  initial
  begin
    void'($urandom(32'haffb));
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    do_read(12'hFFF);
    do_read(12'h000);
    do_read(12'($urandom));
    while (exp_q.size() > 0)
      @(posedge clk);
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule // testbench

`default_nettype wire
